// ---- verilog/occ_pkg.sv ----
// package: register layout, modes and bus constants for the output compare channel
package occ_pkg;

   // register byte addresses on the bus
   localparam logic [7:0]  OCC_CTRL_ADDR   = 8'h00;
   localparam logic [7:0]  OCC_CMP_A_ADDR  = 8'h04;
   localparam logic [7:0]  OCC_CMP_B_ADDR  = 8'h08;
   localparam logic [7:0]  OCC_STAT_ADDR   = 8'h0c;
   localparam logic [7:0]  OCC_MASK_ADDR   = 8'h10;

   // control register field positions
   localparam int          CTRL_IDLE_BIT   = 13;
   localparam int          CTRL_FLT_BIT    = 4;
   localparam int          CTRL_TSEL_BIT   = 3;
   localparam int          CTRL_MODE_LSB   = 0;
   localparam logic [15:0] CTRL_WR_MASK    = 16'h200f;
   localparam logic [15:0] CTRL_RESET      = 16'h0000;
   localparam logic [15:0] CMP_RESET       = 16'h0000;

   // interrupt status bit positions
   localparam int          IRQ_CMP_BIT     = 0;
   localparam int          IRQ_FLT_BIT     = 1;
   localparam int          IRQ_W           = 2;

   // ahb-lite encodings
   localparam logic [1:0]  HTRANS_NONSEQ   = 2'b10;
   localparam logic [1:0]  HTRANS_SEQ      = 2'b11;
   localparam logic        HRESP_OKAY      = 1'b0;

   typedef enum logic [2:0] {
      MODE_OFF     = 3'b000,
      MODE_SET_HI  = 3'b001,
      MODE_SET_LO  = 3'b010,
      MODE_TOGGLE  = 3'b011,
      MODE_SINGLE  = 3'b100,
      MODE_CONT    = 3'b101,
      MODE_PWM     = 3'b110,
      MODE_PWM_FLT = 3'b111
   } occ_mode_t;

   // settings that steer the compare engine
   typedef struct packed {
      logic [15:0] cmp_a;
      logic [15:0] cmp_b;
      occ_mode_t   mode;
      logic        tsel;
      logic        idle_stop;
   } occ_cfg_t;

endpackage

// ---- verilog/occ_sync.sv ----
// two-flop synchroniser for a pin level
`timescale 1ns/10ps
module occ_sync
   import occ_pkg::*;
(
   // clock and reset
   input  wire logic CLK_SYS_I,
   input  wire logic RESET_I,
   // level in and out
   input  wire logic async_i,
   output logic      sync_o
);
   logic meta_q;

   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         meta_q <= 1'b0;
         sync_o <= 1'b0;
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule

// ---- verilog/occ_engine.sv ----
// compare engine: drives the output pin from the selected timer count
`timescale 1ns/10ps
module occ_engine
   import occ_pkg::*;
(
   // clock and reset
   input  wire logic        CLK_SYS_I,
   input  wire logic        RESET_I,
   // configuration
   input  wire occ_cfg_t    cfg_i,
   input  wire logic        run_i,
   input  wire logic        fault_i,
   input  wire logic [15:0] second_timer_i,
   input  wire logic [15:0] third_timer_i,
   // results
   output logic             pin_o,
   output logic             cmp_evt_o,
   output logic             fault_evt_o
);
   occ_mode_t   mode_prev_q;
   logic [15:0] count;
   logic        hit_a;
   logic        hit_b;
   logic        done_q;
   logic        mode_chg;

   assign count    = cfg_i.tsel ? third_timer_i : second_timer_i;  // see (RULE3)
   assign hit_a    = (count == cfg_i.cmp_a);
   assign hit_b    = (count == cfg_i.cmp_b);
   assign mode_chg = (cfg_i.mode != mode_prev_q);

   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         mode_prev_q <= MODE_OFF;
         pin_o       <= 1'b0;
         done_q      <= 1'b0;
         cmp_evt_o   <= 1'b0;
         fault_evt_o <= 1'b0;
      end else begin
         mode_prev_q <= cfg_i.mode;
         cmp_evt_o   <= 1'b0;
         fault_evt_o <= 1'b0;
         if (mode_chg) begin
            // initial pin level on entering a mode; set-low mode starts high
            pin_o  <= (cfg_i.mode == MODE_SET_LO);  // see (RULE9) (RULE7)
            done_q <= 1'b0;
         end else if (run_i) begin  // see (RULE1)
            case (cfg_i.mode)  // see (RULE4)
               MODE_OFF: begin
                  pin_o <= 1'b0;  // see (RULE9)
               end
               MODE_SET_HI: begin
                  if (hit_a && !done_q) begin
                     pin_o     <= 1'b1;  // see (RULE9)
                     done_q    <= 1'b1;
                     cmp_evt_o <= 1'b1;
                  end
               end
               MODE_SET_LO: begin
                  if (hit_a && !done_q) begin
                     pin_o     <= 1'b0;  // see (RULE9)
                     done_q    <= 1'b1;
                     cmp_evt_o <= 1'b1;
                  end
               end
               MODE_TOGGLE: begin
                  if (hit_a) begin
                     pin_o     <= ~pin_o;  // see (RULE9)
                     cmp_evt_o <= 1'b1;
                  end
               end
               MODE_SINGLE, MODE_CONT: begin
                  // rise on a, fall on b; single mode stops after one pulse
                  if (hit_a && !done_q) begin
                     pin_o <= 1'b1;  // see (RULE7) (RULE9)
                  end else if (hit_b && pin_o) begin
                     pin_o     <= 1'b0;
                     cmp_evt_o <= 1'b1;
                     done_q    <= (cfg_i.mode == MODE_SINGLE);
                  end
               end
               MODE_PWM, MODE_PWM_FLT: begin
                  if (cfg_i.mode == MODE_PWM_FLT && fault_i) begin
                     pin_o       <= 1'b0;  // see (RULE5)
                     fault_evt_o <= 1'b1;
                  end else if (count == 16'h0000) begin
                     pin_o <= (cfg_i.cmp_a != 16'h0000);  // see (RULE6)
                  end else if (hit_a) begin
                     pin_o     <= 1'b0;
                     cmp_evt_o <= 1'b1;
                  end
               end
               default: begin
                  pin_o <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule

// ---- verilog/occ_top.sv ----
// output compare channel with ahb-lite register slave and interrupt
//
// The register offsets and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/10ps

// Overview of operation
// (RULE1) idle-stop bit set halts the channel while the cpu is idle.
// (RULE2) fault flag is read-only, set on pwm fault, cleared by hardware only.
// (RULE3) time base select: one picks the third timer, zero the second.
// (RULE4) mode comes from the low three bits of the control register.
// (RULE5) mode 111: pwm with fault input; fault disables output, sets flag.
// (RULE6) mode 110: pwm with the fault input ignored.
// (RULE7) mode 101: pin starts low, then continuous compare-driven pulses.
// (RULE8) unimplemented control bits read zero and ignore writes.
// (RULE9) 100 single pulse, 011 toggle, 010 high then low, 001 low then high.
// (RULE10) fault flag stays cleared unless mode is pwm with fault input.
module occ_top
   import occ_pkg::*;
(
   // clock and reset
   input  wire logic        CLK_SYS_I,
   input  wire logic        RESET_I,
   // ahb-lite slave
   input  wire logic        HSEL_I,
   input  wire logic [7:0]  HADDR_I,
   input  wire logic [1:0]  HTRANS_I,
   input  wire logic        HWRITE_I,
   input  wire logic [2:0]  HSIZE_I,
   input  wire logic [31:0] HWDATA_I,
   input  wire logic        HREADY_I,
   output logic [31:0]      HRDATA_O,
   output logic             HREADYOUT_O,
   output logic             HRESP_O,
   // timers and cpu state
   input  wire logic [15:0] SECOND_TIMER_I,
   input  wire logic [15:0] THIRD_TIMER_I,
   input  wire logic        CPU_IDLE_I,
   // pins
   input  wire logic        FAULT_PIN_I,
   output logic             COMPARE_OUTPUT_PIN_O,
   output logic             IRQ_O
);
   logic [15:0]       ctrl_q;
   logic [15:0]       cmp_a_q;
   logic [15:0]       cmp_b_q;
   logic [IRQ_W-1:0]  stat_q;
   logic [IRQ_W-1:0]  mask_q;
   logic              flt_q;
   logic              wr_pend_q;
   logic [7:0]        wr_addr_q;
   logic              fault_s;
   logic              cmp_evt;
   logic              fault_evt;
   logic              run;
   logic              addr_ok;
   logic [IRQ_W-1:0]  evt;
   logic [IRQ_W-1:0]  w1c;
   logic [31:0]       rd_mux;
   occ_cfg_t          cfg;
   occ_mode_t         mode;

   assign mode = occ_mode_t'(ctrl_q[CTRL_MODE_LSB +: 3]);
   assign run  = !(cfg.idle_stop && CPU_IDLE_I);  // see (RULE1)

   always_comb begin
      cfg.cmp_a     = cmp_a_q;
      cfg.cmp_b     = cmp_b_q;
      cfg.mode      = mode;
      cfg.tsel      = ctrl_q[CTRL_TSEL_BIT];
      cfg.idle_stop = ctrl_q[CTRL_IDLE_BIT];
   end

   // fault pin comes from outside the clock domain
   occ_sync u_fault_sync (
      .CLK_SYS_I (CLK_SYS_I),
      .RESET_I   (RESET_I),
      .async_i   (FAULT_PIN_I),
      .sync_o    (fault_s)
   );

   occ_engine u_engine (
      .CLK_SYS_I   (CLK_SYS_I),
      .RESET_I     (RESET_I),
      .cfg_i       (cfg),
      .run_i       (run),
      .fault_i     (fault_s),
      .second_timer_i    (SECOND_TIMER_I),
      .third_timer_i    (THIRD_TIMER_I),
      .pin_o       (COMPARE_OUTPUT_PIN_O),
      .cmp_evt_o   (cmp_evt),
      .fault_evt_o (fault_evt)
   );

   // address phase capture; writes land one cycle later in the data phase
   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else if (HREADY_I) begin
         wr_pend_q <= HSEL_I && HWRITE_I &&
                      (HTRANS_I == HTRANS_NONSEQ || HTRANS_I == HTRANS_SEQ);
         wr_addr_q <= HADDR_I;
      end
   end

   // control register: only documented bits are writable
   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         ctrl_q <= CTRL_RESET;
      end else if (wr_pend_q && wr_addr_q == OCC_CTRL_ADDR) begin
         ctrl_q <= HWDATA_I[15:0] & CTRL_WR_MASK;  // see (RULE8)
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         cmp_a_q <= CMP_RESET;
         cmp_b_q <= CMP_RESET;
      end else if (wr_pend_q) begin
         if (wr_addr_q == OCC_CMP_A_ADDR) begin
            cmp_a_q <= HWDATA_I[15:0];
         end
         if (wr_addr_q == OCC_CMP_B_ADDR) begin
            cmp_b_q <= HWDATA_I[15:0];
         end
      end
   end

   // fault flag: hardware sets, hardware clears on leaving fault mode or fault end
   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         flt_q <= 1'b0;
      end else if (mode != MODE_PWM_FLT) begin
         flt_q <= 1'b0;  // see (RULE10)
      end else if (fault_evt) begin
         flt_q <= 1'b1;  // see (RULE2) (RULE5)
      end else if (!fault_s) begin
         flt_q <= 1'b0;  // see (RULE2)
      end
   end

   // interrupt status: set beats write-one-to-clear
   assign evt = {fault_evt, cmp_evt};
   assign w1c = (wr_pend_q && wr_addr_q == OCC_STAT_ADDR) ? HWDATA_I[IRQ_W-1:0] : '0;

   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         stat_q <= '0;
      end else begin
         stat_q <= (stat_q & ~w1c) | evt;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         mask_q <= '0;
      end else if (wr_pend_q && wr_addr_q == OCC_MASK_ADDR) begin
         mask_q <= HWDATA_I[IRQ_W-1:0];
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         IRQ_O <= 1'b0;
      end else begin
         IRQ_O <= |(stat_q & mask_q);
      end
   end

   // read data registered in the address phase, shown in the data phase
   always_comb begin
      addr_ok = 1'b1;
      rd_mux  = 32'h0000_0000;
      case (HADDR_I)
         OCC_CTRL_ADDR: begin
            rd_mux[15:0]         = ctrl_q;
            rd_mux[CTRL_FLT_BIT] = flt_q;  // see (RULE2) (RULE8)
         end
         OCC_CMP_A_ADDR: rd_mux[15:0] = cmp_a_q;
         OCC_CMP_B_ADDR: rd_mux[15:0] = cmp_b_q;
         OCC_STAT_ADDR: rd_mux[IRQ_W-1:0] = stat_q;
         OCC_MASK_ADDR: rd_mux[IRQ_W-1:0] = mask_q;
         default: addr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         HRDATA_O <= 32'h0000_0000;
      end else if (HREADY_I && HSEL_I && !HWRITE_I && HTRANS_I[1]) begin
         // unmapped addresses read zero with an okay answer
         HRDATA_O <= addr_ok ? rd_mux : 32'h0000_0000;
      end
   end

   assign HREADYOUT_O = 1'b1;
   assign HRESP_O     = HRESP_OKAY;
endmodule

// ---- verif/occ_top_props.sv ----
// checker: port-level properties of the output compare channel
`timescale 1ns/10ps
module occ_top_props
   import occ_pkg::*;
(
   // clock and reset
   input wire logic        CLK_SYS_I,
   input wire logic        RESET_I,
   // bus
   input wire logic        HSEL_I,
   input wire logic [7:0]  HADDR_I,
   input wire logic [1:0]  HTRANS_I,
   input wire logic        HWRITE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic        HREADY_I,
   input wire logic [31:0] HRDATA_O,
   input wire logic        HREADYOUT_O,
   input wire logic        HRESP_O,
   // timers and pins
   input wire logic [15:0] SECOND_TIMER_I,
   input wire logic [15:0] THIRD_TIMER_I,
   input wire logic        CPU_IDLE_I,
   input wire logic        FAULT_PIN_I,
   input wire logic        COMPARE_OUTPUT_PIN_O
);
   logic        wr_q, rd_q, tsel_q, idle_q;
   logic [7:0]  wa_q;
   logic [1:0]  age_q;
   logic [15:0] cmp_a_q;
   occ_mode_t   mode_q;
   wire logic        take = HSEL_I && HREADY_I && HTRANS_I[1];
   wire logic        pin = COMPARE_OUTPUT_PIN_O;
   wire logic        halt = idle_q && CPU_IDLE_I;
   wire logic        settled = age_q[1];
   wire logic [15:0] cnt = tsel_q ? THIRD_TIMER_I : SECOND_TIMER_I;

   // shadow of written fields, so pin checks need no internal state
   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
      end else begin
         wr_q <= take && HWRITE_I;
         rd_q <= take && !HWRITE_I && HADDR_I == OCC_CTRL_ADDR;
      end
      if (take) wa_q <= HADDR_I;
   end
   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         mode_q <= MODE_OFF;
         tsel_q <= 1'b0;
         idle_q <= 1'b0;
         cmp_a_q <= CMP_RESET;
      end else if (wr_q && wa_q == OCC_CTRL_ADDR) begin
         mode_q <= occ_mode_t'(HWDATA_I[2:0]);
         tsel_q <= HWDATA_I[CTRL_TSEL_BIT];
         idle_q <= HWDATA_I[CTRL_IDLE_BIT];
      end else if (wr_q && wa_q == OCC_CMP_A_ADDR) cmp_a_q <= HWDATA_I[15:0];
   end
   // pin re-initialises after a mode-changing control write, so judge it two edges after any write
   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I || wr_q) age_q <= 2'd0;
      else if (age_q != 2'd3) age_q <= age_q + 2'd1;
   end

   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (RESET_I);

   bus_okay_a: assert property (HREADYOUT_O && !HRESP_O)
      else $error("slave not ready or not okay");
   ctrl_zeros_a: assert property (rd_q |-> (HRDATA_O & 32'hffff_dfe0) == 32'h0)
      else $error("unimplemented control bits read nonzero");
   off_low_a: assert property (settled && mode_q == MODE_OFF |-> !pin)
      else $error("pin high with channel off");
   set_lo_init_a: assert property (wr_q && wa_q == OCC_CTRL_ADDR && HWDATA_I[2:0] == 3'b010
      |-> ##[1:3] pin) else $error("pin not set high on mode entry");
   cont_init_a: assert property (wr_q && wa_q == OCC_CTRL_ADDR && HWDATA_I[2:0] == 3'b101
      |-> ##[1:3] !pin) else $error("pin not set low on mode entry");
   toggle_a: assert property (settled && mode_q == MODE_TOGGLE && cnt == cmp_a_q && !halt
      |=> pin != $past(pin)) else $error("pin did not toggle on match");
   pwm_fall_a: assert property (settled && mode_q inside {MODE_PWM, MODE_PWM_FLT}
      && cnt == cmp_a_q && !halt |=> !pin) else $error("pwm did not fall at duty");
   pwm_rise_a: assert property (settled && mode_q == MODE_PWM && cnt == 16'h0
      && cmp_a_q != 16'h0 && !halt |=> pin) else $error("pwm did not rise at zero");
   fault_off_a: assert property ((settled && mode_q == MODE_PWM_FLT && FAULT_PIN_I)[*4]
      |-> !pin) else $error("pin driven during fault");
   idle_hold_a: assert property ($past(halt) |-> $stable(pin))
      else $error("pin moved while halted");

   cover property (rd_q);
   cover property (mode_q == MODE_PWM_FLT && FAULT_PIN_I);
   cover property (halt && mode_q == MODE_TOGGLE);
endmodule

bind occ_top occ_top_props i_occ_top_props (
   .CLK_SYS_I(CLK_SYS_I), .RESET_I(RESET_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
   .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I),
   .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
   .SECOND_TIMER_I(SECOND_TIMER_I), .THIRD_TIMER_I(THIRD_TIMER_I), .CPU_IDLE_I(CPU_IDLE_I),
   .FAULT_PIN_I(FAULT_PIN_I), .COMPARE_OUTPUT_PIN_O(COMPARE_OUTPUT_PIN_O)
);

// ---- verif/occ_far_side.sv ----
// far-side model: two free-running timers and the fault pin
`timescale 1ns/10ps
module occ_far_side
   import occ_pkg::*;
#(
   // short wraps keep pwm periods and the run short
   parameter int SECOND_PERIOD = 64,
   parameter int THIRD_PERIOD  = 100
)(
   // clock and reset
   input  wire logic        CLK_SYS_I,
   input  wire logic        RESET_I,
   // stimulus and outputs
   input  wire logic        fault_req_i,
   output logic [15:0]      second_timer_o,
   output logic [15:0]      third_timer_o,
   output logic             fault_pin_o
);
   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) second_timer_o <= 16'h0000;
      else if (second_timer_o == 16'(SECOND_PERIOD - 1)) second_timer_o <= 16'h0000;
      else second_timer_o <= second_timer_o + 16'h0001;
   end
   // offset start so the two time bases first run in step 768 cycles after reset
   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) third_timer_o <= 16'h0020;
      else if (third_timer_o == 16'(THIRD_PERIOD - 1)) third_timer_o <= 16'h0000;
      else third_timer_o <= third_timer_o + 16'h0001;
   end
   always_ff @(posedge CLK_SYS_I) fault_pin_o <= fault_req_i;
endmodule

// ---- verif/occ_top_test.sv ----
// testbench: register-level tests of the output compare channel
`timescale 1ns/10ps
module occ_top_test
   import occ_pkg::*;
;
   logic        clk, rst, hsel, hwrite, idle, fault_req, pin, irq, hready, hresp, fpin, tsel;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic [31:0] hwdata, hrdata, rd;
   logic [15:0] t2, t3;
   logic [3:0]  tbl [1:5];
   int          fails, total_checks;

   occ_top i_occ_top (.CLK_SYS_I(clk), .RESET_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
      .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'b010), .HWDATA_I(hwdata),
      .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
      .SECOND_TIMER_I(t2), .THIRD_TIMER_I(t3), .CPU_IDLE_I(idle), .FAULT_PIN_I(fpin),
      .COMPARE_OUTPUT_PIN_O(pin), .IRQ_O(irq));
   occ_far_side i_occ_far_side (.CLK_SYS_I(clk), .RESET_I(rst), .fault_req_i(fault_req),
      .second_timer_o(t2), .third_timer_o(t3), .fault_pin_o(fpin));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wait_cnt(input logic [15:0] v);
      do @(posedge clk); while ((tsel ? t3 : t2) !== v);
   endtask
   task automatic pin_at(input logic [15:0] v, input logic e);
      wait_cnt(v);
      chk({31'h0, pin}, {31'h0, e});
   endtask
   task automatic print_verdict;
      $display("checks %0d, mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      print_verdict();
   end

   initial begin
      {rst, hsel, htrans, haddr, hwrite, hwdata, idle, fault_req, tsel} = '0;
      rst = 1'b1;
      fails = 0;
      total_checks = 0;
      // pin after entry, first A, B, next A
      tbl = '{4'h7, 4'h8, 4'h6, 4'h4, 4'h5};
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      bus(OCC_CTRL_ADDR, 1'b0, 32'h0);
      chk(rd, {16'h0000, CTRL_RESET});
      bus(OCC_CTRL_ADDR, 1'b1, 32'hffff_fff8);
      bus(OCC_CTRL_ADDR, 1'b0, 32'h0);
      chk(rd, 32'h0000_2008);
      bus(8'h40, 1'b1, 32'hffff_ffff);
      bus(8'h40, 1'b0, 32'h0);
      chk(rd, 32'h0);
      $display("test registers done");
      bus(OCC_CMP_A_ADDR, 1'b1, 32'd10);
      bus(OCC_CMP_B_ADDR, 1'b1, 32'd30);
      for (int m = 1; m <= 5; m++) begin
         tsel = m[0];
         wait_cnt(16'd40);
         bus(OCC_CTRL_ADDR, 1'b1, {28'h0, tsel, m[2:0]});
         pin_at(16'd5, tbl[m][3]);
         pin_at(16'd15, tbl[m][2]);
         pin_at(16'd35, tbl[m][1]);
         pin_at(16'd15, tbl[m][0]);
      end
      $display("test compare modes done");
      tsel = 1'b0;
      bus(OCC_CMP_A_ADDR, 1'b1, 32'd20);
      fault_req <= 1'b1;
      wait_cnt(16'd40);
      bus(OCC_CTRL_ADDR, 1'b1, 32'h6);
      pin_at(16'd10, 1'b1);
      pin_at(16'd25, 1'b0);
      bus(OCC_CTRL_ADDR, 1'b0, 32'h0);
      chk(rd, 32'h6);
      fault_req <= 1'b0;
      bus(OCC_CTRL_ADDR, 1'b1, 32'h7);
      repeat (4) @(posedge clk);
      fault_req <= 1'b1;
      repeat (8) @(posedge clk);
      chk({31'h0, pin}, 32'h0);
      bus(OCC_CTRL_ADDR, 1'b1, 32'h7);
      bus(OCC_CTRL_ADDR, 1'b0, 32'h0);
      chk(rd, 32'h17);
      bus(OCC_MASK_ADDR, 1'b1, 32'h2);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      bus(OCC_MASK_ADDR, 1'b1, 32'h0);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      fault_req <= 1'b0;
      repeat (8) @(posedge clk);
      bus(OCC_CTRL_ADDR, 1'b0, 32'h0);
      chk(rd, 32'h7);
      bus(OCC_STAT_ADDR, 1'b1, 32'h2);
      bus(OCC_STAT_ADDR, 1'b0, 32'h0);
      chk(rd & 32'h2, 32'h0);
      bus(OCC_MASK_ADDR, 1'b1, 32'h2);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      $display("test pwm and fault done");
      wait_cnt(16'd40);
      bus(OCC_CTRL_ADDR, 1'b1, 32'h2003);
      wait_cnt(16'd5);
      idle <= 1'b1;
      pin_at(16'd30, 1'b0);
      idle <= 1'b0;
      wait_cnt(16'd40);
      bus(OCC_CTRL_ADDR, 1'b1, 32'h3);
      wait_cnt(16'd5);
      idle <= 1'b1;
      pin_at(16'd30, 1'b1);
      idle <= 1'b0;
      $display("test idle stop done");
      print_verdict();
   end
endmodule
